// ===== rtl/sdm_pkg.sv
/*
 package for the supply drop monitor register bank: offsets, field positions,
 reset values and timing constants. assumes an 8-bit register port with 16-bit address.
*/
package sdm_pkg;
   // ==========================================
   // register offsets
   localparam logic [15:0] ADDR_MON_ENABLE = 16'h5100;
   localparam logic [15:0] ADDR_THRESHOLD_SELECT = 16'h5101;
   localparam logic [15:0] ADDR_COMPARE_RESULT = 16'h5102;
   localparam logic [15:0] ADDR_DROP_IRQ_MASK = 16'h5103;
   localparam logic [15:0] ADDR_DROP_IRQ_FLAG_REG = 16'h5104;
   // ==========================================
   // fields and reset values
   localparam int BIT_D0 = 0;
   localparam logic [3:0] THRESHOLD_RESET = 4'h0;
   localparam logic [3:0] THRESHOLD_FIRST_VALID = 4'h3;
   localparam logic [7:0] DATA_ZERO = 8'h00;
   // ==========================================
   // timing
   localparam int CLK_FREQ_KHZ = 50000;
   localparam int SETTLE_TIME_US = 500;
   localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_FREQ_KHZ / 1000;
   localparam int SETTLE_W = 15;
   localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 15'h0000;
   localparam logic [SETTLE_W-1:0] SETTLE_ONE = 15'h0001;
   // ==========================================
   // arm fsm
   typedef enum logic [1:0] {
      SDM_IDLE = 2'b00,
      SDM_SETTLING = 2'b01,
      SDM_ARMED = 2'b11
   } sdm_state_t;
endpackage

// ===== rtl/sdm_sync.sv
/*
 two flip-flop synchroniser for the comparator level.
 assumes input is asynchronous to core_clk.
*/
`timescale 1ns/1ps
module sdm_sync (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   typedef struct packed {
      logic meta;
      logic stable;
   } sdm_sync_st_t;
   sdm_sync_st_t s_q, s_d;
   // first stage is read only by the second stage
   always_comb begin
      s_d = s_q;
      s_d.meta = async_in;
      s_d.stable = s_q.meta;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign sync_out = s_q.stable;
endmodule // sdm_sync

// ===== rtl/sdm_edge.sv
/*
 falling-to-below edge detector, qualified by an enable.
 assumes a synchronous input.
*/
`timescale 1ns/1ps
module sdm_edge (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic level_in,
   output logic rise_pulse
);
   typedef struct packed {
      logic prev;
   } sdm_edge_st_t;
   sdm_edge_st_t e_q, e_d;
   // prev held high when disabled so a below level at enable is not an edge
   always_comb begin
      e_d = e_q;
      e_d.prev = enable ? level_in : 1'b1;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         // idle level of prev is high, so no false edge follows reset
         e_q <= '1;
      end else begin
         e_q <= e_d;
      end
   end
   assign rise_pulse = enable & level_in & ~e_q.prev;
endmodule // sdm_edge

// ===== rtl/sdm_regs.sv
/*
 register bank and interrupt logic of the supply drop monitor.
 assumes a single-cycle strobe register port and an external comparator
 giving an asynchronous below-threshold level.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module sdm_regs (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic below_threshold_async,
   output logic compare_enable,
   output logic [3:0] threshold_code,
   output logic result_settled,
   output logic irq_req
);
   // ==========================================
   // state
   typedef struct packed {
      logic monitor_enable_bit;
      logic [3:0] threshold_code;
      logic drop_irq_enable;
      logic drop_irq_flag;
      logic [7:0] rdata;
      sdm_pkg::sdm_state_t arm;
      logic [sdm_pkg::SETTLE_W-1:0] settle_cnt;
   } sdm_regs_st_t;
   sdm_regs_st_t r_q, r_d;
   logic below_sync;
   logic drop_event;
   logic below_threshold_result;
   logic wr_en, wr_flag, wr_mask, wr_thr;
   logic [7:0] rd_mux;
   // ==========================================
   // comparator path
   sdm_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(below_threshold_async),
      .sync_out(below_sync)
   );
   // result is forced to zero while the comparator is stopped
   assign below_threshold_result = r_q.monitor_enable_bit & below_sync;
   sdm_edge u_edge (
      .core_clk(core_clk),
      .rst(rst),
      .enable(r_q.monitor_enable_bit),
      .level_in(below_sync),
      .rise_pulse(drop_event)
   );
   // ==========================================
   // decode
   assign wr_en = reg_wr && (reg_addr == sdm_pkg::ADDR_MON_ENABLE);
   assign wr_thr = reg_wr && (reg_addr == sdm_pkg::ADDR_THRESHOLD_SELECT);
   assign wr_mask = reg_wr && (reg_addr == sdm_pkg::ADDR_DROP_IRQ_MASK);
   assign wr_flag = reg_wr && (reg_addr == sdm_pkg::ADDR_DROP_IRQ_FLAG_REG);
   always_comb begin
      rd_mux = sdm_pkg::DATA_ZERO;
      unique case (reg_addr)
         sdm_pkg::ADDR_MON_ENABLE: rd_mux[sdm_pkg::BIT_D0] = r_q.monitor_enable_bit;
         sdm_pkg::ADDR_THRESHOLD_SELECT: rd_mux[3:0] = r_q.threshold_code;
         sdm_pkg::ADDR_COMPARE_RESULT: rd_mux[sdm_pkg::BIT_D0] = below_threshold_result;
         sdm_pkg::ADDR_DROP_IRQ_MASK: rd_mux[sdm_pkg::BIT_D0] = r_q.drop_irq_enable;
         sdm_pkg::ADDR_DROP_IRQ_FLAG_REG: rd_mux[sdm_pkg::BIT_D0] = r_q.drop_irq_flag;
         default: rd_mux = sdm_pkg::DATA_ZERO;
      endcase
   end
   // ==========================================
   // next state
   always_comb begin
      r_d = r_q;
      r_d.rdata = reg_rd ? rd_mux : sdm_pkg::DATA_ZERO;
      if (wr_en) begin
         r_d.monitor_enable_bit = reg_wdata[sdm_pkg::BIT_D0];
      end
      if (wr_thr) begin
         r_d.threshold_code = reg_wdata[3:0];
      end
      if (wr_mask) begin
         r_d.drop_irq_enable = reg_wdata[sdm_pkg::BIT_D0];
      end
      // set wins over a same-cycle write-one clear
      if (wr_flag && reg_wdata[sdm_pkg::BIT_D0]) begin
         r_d.drop_irq_flag = 1'b0;
      end
      if (drop_event) begin
         r_d.drop_irq_flag = 1'b1;
      end
      // settle tracker: informational, raised when result is trustworthy
      unique case (r_q.arm)
         sdm_pkg::SDM_IDLE: begin
            r_d.settle_cnt = sdm_pkg::SETTLE_ZERO;
            if (r_q.monitor_enable_bit) begin
               r_d.arm = sdm_pkg::SDM_SETTLING;
            end
         end
         sdm_pkg::SDM_SETTLING: begin
            if (!r_q.monitor_enable_bit) begin
               r_d.arm = sdm_pkg::SDM_IDLE;
            end else if (r_q.settle_cnt == sdm_pkg::SETTLE_W'(sdm_pkg::SETTLE_CYCLES - 1)) begin
               r_d.arm = sdm_pkg::SDM_ARMED;
            end else begin
               r_d.settle_cnt = r_q.settle_cnt + sdm_pkg::SETTLE_ONE;
            end
         end
         sdm_pkg::SDM_ARMED: begin
            if (!r_q.monitor_enable_bit) begin
               r_d.arm = sdm_pkg::SDM_IDLE;
            end
         end
         default: r_d.arm = sdm_pkg::SDM_IDLE;
      endcase
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
   // ==========================================
   // outputs
   assign reg_rdata = r_q.rdata;
   assign compare_enable = r_q.monitor_enable_bit;
   assign threshold_code = r_q.threshold_code;
   assign result_settled = (r_q.arm == sdm_pkg::SDM_ARMED);
   // level request, so the controller must be level triggered
   assign irq_req = r_q.drop_irq_flag & r_q.drop_irq_enable;
   // ==========================================
   // assertions
   sequence wr_one_clear_s;
      wr_flag && reg_wdata[0] && !drop_event;
   endsequence
   irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
      irq_req == (r_q.drop_irq_flag && r_q.drop_irq_enable))
      else $error("irq request not flag and enable");
   flag_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_one_clear_s |=> !r_q.drop_irq_flag)
      else $error("write one did not clear flag");
   flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (r_q.drop_irq_flag && !(wr_flag && reg_wdata[0])) |=> r_q.drop_irq_flag)
      else $error("flag dropped without clear");
   flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
      drop_event |=> r_q.drop_irq_flag)
      else $error("drop event did not set flag");
   edge_only_a: assert property (@(posedge core_clk) disable iff (rst)
      (!r_q.drop_irq_flag && !drop_event) |=> !r_q.drop_irq_flag)
      else $error("flag set without edge");
   disabled_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
      !r_q.monitor_enable_bit |-> (!drop_event && !below_threshold_result))
      else $error("activity while disabled");
   read_data_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr != sdm_pkg::ADDR_THRESHOLD_SELECT |=> reg_rdata[7:1] == 7'h00)
      else $error("upper bits not zero");
   result_read_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == sdm_pkg::ADDR_COMPARE_RESULT
      |=> reg_rdata[0] == $past(below_threshold_result))
      else $error("result read mismatch");
   mask_reset_a: assert property (@(posedge core_clk) disable iff (rst)
      !r_q.drop_irq_enable |-> !irq_req)
      else $error("request while masked");
   thr_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_thr |=> threshold_code == $past(reg_wdata[3:0]))
      else $error("threshold write lost");

   // ==========================================
   // assertions: register writes, holds and reads
   sequence rd_at_s(logic [15:0] a);
      reg_rd && (reg_addr == a);
   endsequence

   en_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_en
      |=> compare_enable == $past(reg_wdata[sdm_pkg::BIT_D0]))
      else $error("enable write lost");

   en_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !wr_en
      |=> $stable(compare_enable))
      else $error("enable changed without write");

   thr_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !wr_thr
      |=> $stable(threshold_code))
      else $error("threshold changed without write");

   thr_read_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_at_s(sdm_pkg::ADDR_THRESHOLD_SELECT)
      |=> reg_rdata == {4'h0, $past(r_q.threshold_code)})
      else $error("threshold read mismatch");

   mask_write_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_mask
      |=> r_q.drop_irq_enable == $past(reg_wdata[sdm_pkg::BIT_D0]))
      else $error("irq enable write lost");

   mask_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      !wr_mask
      |=> $stable(r_q.drop_irq_enable))
      else $error("irq enable changed without write");

   flag_read_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_at_s(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG)
      |=> reg_rdata == {7'h00, $past(r_q.drop_irq_flag)})
      else $error("flag read mismatch");

   en_read_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_at_s(sdm_pkg::ADDR_MON_ENABLE)
      |=> reg_rdata == {7'h00, $past(r_q.monitor_enable_bit)})
      else $error("enable read mismatch");

   mask_read_a: assert property (@(posedge core_clk) disable iff (rst)
      rd_at_s(sdm_pkg::ADDR_DROP_IRQ_MASK)
      |=> reg_rdata == {7'h00, $past(r_q.drop_irq_enable)})
      else $error("irq enable read mismatch");

   unmapped_read_a: assert property (@(posedge core_clk) disable iff (rst)
      reg_rd && !(reg_addr inside {[sdm_pkg::ADDR_MON_ENABLE:sdm_pkg::ADDR_DROP_IRQ_FLAG_REG]})
      |=> reg_rdata == sdm_pkg::DATA_ZERO)
      else $error("unmapped read not zero");

   rdata_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      !reg_rd
      |=> reg_rdata == sdm_pkg::DATA_ZERO)
      else $error("read data outside read slot");

   // ==========================================
   // assertions: comparator path and flag
   // the two-cycle guard keeps the check off the synchroniser's reset flush
   sequence below_rise_s;
      (r_q.monitor_enable_bit && !below_sync) ##1 (r_q.monitor_enable_bit && below_sync);
   endsequence

   sync_delay_a: assert property (@(posedge core_clk) disable iff (rst)
      !$past(rst) && !$past(rst, 2)
      |-> below_sync == $past(below_threshold_async, 2))
      else $error("synchroniser delay wrong");

   result_live_a: assert property (@(posedge core_clk) disable iff (rst)
      r_q.monitor_enable_bit && !$past(rst) && !$past(rst, 2)
      |-> below_threshold_result == $past(below_threshold_async, 2))
      else $error("result not following comparator");

   edge_set_a: assert property (@(posedge core_clk) disable iff (rst)
      below_rise_s
      |=> r_q.drop_irq_flag)
      else $error("enabled drop did not set flag");

   edge_cause_a: assert property (@(posedge core_clk) disable iff (rst)
      drop_event
      |-> $past(r_q.monitor_enable_bit) && !$past(below_sync) && below_sync)
      else $error("drop event without enabled rise");

   unmask_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_mask && !r_q.drop_irq_flag && !drop_event
      |=> !irq_req)
      else $error("unmask raised request without flag");

   irq_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      irq_req
      |-> r_q.drop_irq_flag)
      else $error("request without flag");

   clear_irq_a: assert property (@(posedge core_clk) disable iff (rst)
      wr_one_clear_s
      |=> !irq_req)
      else $error("flag clear left request up");

   flag_fall_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(r_q.drop_irq_flag)
      |-> $past(wr_flag && reg_wdata[sdm_pkg::BIT_D0]))
      else $error("flag fell without write one");

   // ==========================================
   // assertions: settle tracker
   settle_off_a: assert property (@(posedge core_clk) disable iff (rst)
      !r_q.monitor_enable_bit
      |=> !result_settled)
      else $error("settled while disabled");

   settle_time_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(result_settled)
      |-> r_q.settle_cnt == sdm_pkg::SETTLE_W'(sdm_pkg::SETTLE_CYCLES - 1))
      else $error("settled before full count");

   settle_cnt_a: assert property (@(posedge core_clk) disable iff (rst)
      r_q.arm == sdm_pkg::SDM_SETTLING
      |-> r_q.settle_cnt < sdm_pkg::SETTLE_W'(sdm_pkg::SETTLE_CYCLES))
      else $error("settle counter overran");
endmodule // sdm_regs

// ===== dv/sdm_cmp_model.sv
/*
 behavioural comparator at the far side of the supply drop monitor.
 assumes the bench gives the supply as a level in threshold-code units.
*/
`timescale 1ns/1ps
module sdm_cmp_model (
   input wire logic [3:0] threshold_code,
   input wire logic [3:0] supply_lvl,
   output logic below_threshold_async
);
   // ====================
   // comparison
   // output is left live while stopped so that ungated use of it shows up
   assign below_threshold_async = supply_lvl < threshold_code;
endmodule // sdm_cmp_model

// ===== dv/tb_top.sv
/*
 self-checking bench for the supply drop monitor register bank.
 assumes a 50 MHz core_clk and the comparator model at the far side.
*/
`timescale 1ns/1ps
module tb_top;
   logic core_clk, rst, reg_wr, reg_rd, below_threshold_async;
   logic compare_enable, result_settled, irq_req, rd_seen;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [3:0] threshold_code, supply_lvl, code;
   logic [7:0] exp_q[$];
   int fail_count, checks;
   sdm_regs sdm_regs_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .below_threshold_async(below_threshold_async), .compare_enable(compare_enable),
      .threshold_code(threshold_code), .result_settled(result_settled), .irq_req(irq_req));
   sdm_cmp_model sdm_cmp_model_i (.threshold_code(threshold_code), .supply_lvl(supply_lvl),
      .below_threshold_async(below_threshold_async));
   // ====================
   // helpers
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic ochk(string n, logic e, ref logic g);
      @(negedge core_clk);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask
   task end_sim;
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ====================
   // clock, read monitor, watchdog
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // read data stand only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_seen === 1'b1) begin
         chk("reg_rdata", exp_q.pop_front(), reg_rdata);
      end
      rd_seen <= reg_rd;
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
   // ====================
   // scenarios
   initial begin
      rst = 1'b1;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rd_seen = 1'b0;
      supply_lvl = 4'hf;
      void'($urandom(80629));
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      for (int a = 0; a < 6; a++) rd(sdm_pkg::ADDR_MON_ENABLE + a[15:0], 8'h00);
      for (int c = 0; c < 16; c++) begin
         wr(sdm_pkg::ADDR_THRESHOLD_SELECT, {4'($urandom), c[3:0]});
         rd(sdm_pkg::ADDR_THRESHOLD_SELECT, {4'h0, c[3:0]});
      end
      wr(sdm_pkg::ADDR_COMPARE_RESULT, 8'hff);
      rd(sdm_pkg::ADDR_COMPARE_RESULT, 8'h00);
      code = 4'h3 + 4'($urandom_range(12));
      wr(sdm_pkg::ADDR_THRESHOLD_SELECT, {4'h0, code});
      @(negedge core_clk);
      chk("threshold_code", {4'h0, code}, {4'h0, threshold_code});
      supply_lvl <= code;
      wr(sdm_pkg::ADDR_MON_ENABLE, 8'hff);
      rd(sdm_pkg::ADDR_MON_ENABLE, 8'h01);
      ochk("compare_enable", 1'b1, compare_enable);
      ochk("result_settled", 1'b0, result_settled);
      rd(sdm_pkg::ADDR_COMPARE_RESULT, 8'h00);
      supply_lvl <= code - 4'h1;
      repeat (5) @(posedge core_clk);
      rd(sdm_pkg::ADDR_COMPARE_RESULT, 8'h01);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h01);
      ochk("irq_req", 1'b0, irq_req);
      wr(sdm_pkg::ADDR_DROP_IRQ_MASK, 8'hff);
      rd(sdm_pkg::ADDR_DROP_IRQ_MASK, 8'h01);
      ochk("irq_req", 1'b1, irq_req);
      supply_lvl <= code;
      repeat (5) @(posedge core_clk);
      ochk("irq_req", 1'b1, irq_req);
      rd(sdm_pkg::ADDR_COMPARE_RESULT, 8'h00);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h01);
      wr(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'hfe);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h01);
      wr(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h01);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h00);
      ochk("irq_req", 1'b0, irq_req);
      // software order: clear the flag before unmasking
      wr(sdm_pkg::ADDR_DROP_IRQ_MASK, 8'h00);
      supply_lvl <= code - 4'h1;
      repeat (5) @(posedge core_clk);
      ochk("irq_req", 1'b0, irq_req);
      wr(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h01);
      wr(sdm_pkg::ADDR_DROP_IRQ_MASK, 8'h01);
      repeat (5) @(posedge core_clk);
      ochk("irq_req", 1'b0, irq_req);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h00);
      wr(sdm_pkg::ADDR_MON_ENABLE, 8'h00);
      ochk("compare_enable", 1'b0, compare_enable);
      supply_lvl <= code;
      repeat (5) @(posedge core_clk);
      supply_lvl <= code - 4'h1;
      repeat (5) @(posedge core_clk);
      rd(sdm_pkg::ADDR_DROP_IRQ_FLAG_REG, 8'h00);
      rd(sdm_pkg::ADDR_COMPARE_RESULT, 8'h00);
      ochk("irq_req", 1'b0, irq_req);
      supply_lvl <= code;
      wr(sdm_pkg::ADDR_MON_ENABLE, 8'h01);
      repeat (sdm_pkg::SETTLE_CYCLES + 10) @(posedge core_clk);
      ochk("result_settled", 1'b1, result_settled);
      repeat (3) @(posedge core_clk);
      end_sim();
   end
endmodule // tb_top
